// ==== logic/aux_sampler.sv ====
// Captures the auxiliary power sense level once it has settled after reset
module aux_sampler (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic sense_sync_i,
  output pm_cap_pkg::aux_status_t status_o
);

  typedef struct packed {
    logic last_level;
    logic [pm_cap_pkg::SETTLE_W-1:0] count;
    pm_cap_pkg::aux_status_t status;
  } sampler_state_t;

  sampler_state_t st;
  sampler_state_t next_st;

  always_comb begin
    next_st = st;
    if (ce_i && !st.status.done) begin
      next_st.last_level = sense_sync_i;
      if (sense_sync_i != st.last_level) begin
        next_st.count = pm_cap_pkg::SETTLE_RESET;
      end else if (st.count == pm_cap_pkg::SETTLE_LAST) begin
        // A floating pin reads high and so reports no auxiliary supply
        next_st.status.aux_present = !sense_sync_i;
        next_st.status.done = 1'b1;
      end else begin
        next_st.count = st.count + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.last_level <= 1'b1;
      st.count <= pm_cap_pkg::SETTLE_RESET;
      st.status <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  assign status_o = st.status;

endmodule

// ==== logic/level_sync.sv ====
// Two-flop synchroniser for one level from outside the clock domain
module level_sync (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic reset_level_i,
  input wire logic async_i,
  output logic sync_o
);

  typedef struct packed {
    logic first;
    logic second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    if (ce_i) begin
      next_st.first = async_i;
      next_st.second = st.first;
    end
  end

  // Reset value is the constant 2'h3; the level input is not used
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.second;

endmodule

// ==== logic/pm_capabilities_register.sv ====
// Read-only power management capabilities dword answering configuration cycles
module pm_capabilities_register (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic aux_power_sense_i,
  input wire pm_cap_pkg::cfg_req_t cfg_req_i,
  output pm_cap_pkg::cfg_rsp_t cfg_rsp_o,
  output logic [15:0] power_capabilities_o,
  output logic aux_power_status_o,
  output logic sample_done_o
);

  typedef struct packed {
    pm_cap_pkg::cfg_state_t state;
    logic [3:0] byte_en;
    logic [15:0] caps;
    logic aux_present;
    logic done;
    pm_cap_pkg::cfg_rsp_t rsp;
  } reg_state_t;

  reg_state_t st;
  reg_state_t next_st;
  logic sense_sync;
  pm_cap_pkg::aux_status_t aux_status;

  // Pin crosses into the clock domain before the sampler looks at it
  level_sync u_sense_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .reset_level_i(1'b1),
    .async_i(aux_power_sense_i),
    .sync_o(sense_sync)
  );

  aux_sampler u_sampler (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .sense_sync_i(sense_sync),
    .status_o(aux_status)
  );

  // Builds the 16-bit capabilities half from the captured supply status
  function automatic logic [15:0] compose_caps(input logic aux_present);
    logic [15:0] v;
    v = 16'h0000;
    // Each wake bit stands for one power state; a zero bars the wake signal there
    if (aux_present) begin
      v[pm_cap_pkg::WAKE_LSB +: 5] = pm_cap_pkg::WAKE_WITH_AUX;
    end else begin
      v[pm_cap_pkg::WAKE_LSB +: 5] = pm_cap_pkg::WAKE_WITHOUT_AUX;
    end
    v[pm_cap_pkg::D2_POS] = pm_cap_pkg::D2_SUPPORTED;
    v[pm_cap_pkg::D1_POS] = pm_cap_pkg::D1_SUPPORTED;
    v[pm_cap_pkg::RSVD_LSB +: 3] = pm_cap_pkg::RSVD_VALUE;
    v[pm_cap_pkg::DSI_POS] = pm_cap_pkg::DSI_VALUE;
    v[pm_cap_pkg::AUX_REQ_POS] = pm_cap_pkg::AUX_REQ_VALUE;
    v[pm_cap_pkg::PME_CLK_POS] = pm_cap_pkg::PME_CLK_VALUE;
    v[pm_cap_pkg::VERSION_LSB +: 3] = pm_cap_pkg::VERSION_VALUE;
    return v;
  endfunction

  // Expands byte enables into a lane mask so disabled lanes read zero
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Dword at the capability index, lanes masked by the byte enables; anything else is unmapped and reads zero
  function automatic logic [31:0] read_dword(
    input logic [5:0] index,
    input logic [3:0] be,
    input logic [15:0] caps
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    if (index == pm_cap_pkg::CAP_DWORD_INDEX) begin
      d = {caps, pm_cap_pkg::CAP_NEXT_PTR, pm_cap_pkg::CAP_ID_VALUE};
    end
    return d & lane_mask(be);
  endfunction

  always_comb begin
    next_st = st;
    if (ce_i) begin
      next_st.rsp.ack = 1'b0;
      next_st.rsp.retry = 1'b0;
      // Status is frozen once captured; later pin moves do not alter the report
      next_st.aux_present = aux_status.aux_present;
      next_st.done = aux_status.done;
      next_st.caps = compose_caps(aux_status.aux_present);
      unique case (st.state)
        pm_cap_pkg::ST_IDLE: begin
          if (cfg_req_i.valid) begin
            if (!st.done) begin
              // Registered flag gates answers, so the built dword already holds the capture
              next_st.rsp.retry = 1'b1;
            end else begin
              next_st.rsp.ack = 1'b1;
              next_st.byte_en = cfg_req_i.byte_en;
              if (cfg_req_i.write) begin
                // Write data is dropped; the dword stays as built
                next_st.rsp.rdata = pm_cap_pkg::RDATA_RESET;
              end else begin
                next_st.rsp.rdata = read_dword(cfg_req_i.index, cfg_req_i.byte_en,
                                               st.caps);
              end
              next_st.state = pm_cap_pkg::ST_PARITY;
            end
          end
        end
        pm_cap_pkg::ST_PARITY: begin
          // Even parity over data and enables, one cycle behind the data
          next_st.rsp.par = ^{st.rsp.rdata, st.byte_en};
          next_st.state = pm_cap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.state <= pm_cap_pkg::ST_IDLE;
      st.byte_en <= pm_cap_pkg::BE_RESET;
      st.caps <= pm_cap_pkg::CAPS_RESET;
      st.aux_present <= 1'b0;
      st.done <= 1'b0;
      st.rsp.ack <= 1'b0;
      st.rsp.retry <= 1'b0;
      st.rsp.rdata <= pm_cap_pkg::RDATA_RESET;
      st.rsp.par <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rsp_o = st.rsp;
  assign power_capabilities_o = st.caps;
  assign aux_power_status_o = st.aux_present;
  assign sample_done_o = st.done;

endmodule

// ==== pkg/pm_cap_pkg.sv ====
// Constants, field layout and carrier types of the power management capabilities block
package pm_cap_pkg;

  // Position of the capability dword in configuration space, as a dword index
  localparam logic [5:0] CAP_DWORD_INDEX = 6'h37;
  localparam logic [7:0] CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] CAP_NEXT_PTR = 8'h00;

  // Field positions inside the 16-bit capabilities half (bit 0 is dword bit 16)
  localparam int WAKE_LSB = 11;
  localparam int D2_POS = 10;
  localparam int D1_POS = 9;
  localparam int RSVD_LSB = 6;
  localparam int DSI_POS = 5;
  localparam int AUX_REQ_POS = 4;
  localparam int PME_CLK_POS = 3;
  localparam int VERSION_LSB = 0;
  localparam int CAPS_DWORD_LSB = 16;

  // Field values
  localparam logic [4:0] WAKE_WITH_AUX = 5'h1f;
  localparam logic [4:0] WAKE_WITHOUT_AUX = 5'h03;
  localparam logic D2_SUPPORTED = 1'h1;
  localparam logic D1_SUPPORTED = 1'h1;
  localparam logic [2:0] RSVD_VALUE = 3'h0;
  localparam logic DSI_VALUE = 1'h1;
  localparam logic AUX_REQ_VALUE = 1'h0;
  localparam logic PME_CLK_VALUE = 1'h0;
  localparam logic [2:0] VERSION_VALUE = 3'h1;

  // Values after reset
  localparam logic [15:0] CAPS_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [3:0] BE_RESET = 4'h0;

  // Cycles the synchronised sense level must hold still before it is captured
  localparam int SETTLE_TIME_NS = 160;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_RESET = 5'h00;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_PARITY
  } cfg_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] index;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic ack;
    logic retry;
    logic [31:0] rdata;
    logic par;
  } cfg_rsp_t;

  typedef struct packed {
    logic aux_present;
    logic done;
  } aux_status_t;

endpackage

// ==== test/pci_host_model.sv ====
// Configuration cycle host facing the capabilities register
module pci_host_model (
  input wire logic mclk_i,
  input wire pm_cap_pkg::cfg_rsp_t cfg_rsp_i,
  output pm_cap_pkg::cfg_req_t cfg_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cfg_req_o = '0;
  // Released fields are inverted so stale values never pass for a request
  task automatic cfg(input logic w, input logic [5:0] idx, input logic [3:0] be,
                     input logic [31:0] wd, output pm_cap_pkg::cfg_rsp_t r);
    @(posedge mclk_i);
    cfg_req_o <= '{1'b1, w, idx, be, wd};
    @(posedge mclk_i);
    cfg_req_o <= '{1'b0, ~w, ~idx, ~be, ~wd};
    @(posedge mclk_i);
    r = cfg_rsp_i;
    // Spare edge lets the parity bit register before the caller reads it
    @(posedge mclk_i);
  endtask
endmodule

// ==== test/pm_cap_assertions.sv ====
// Port checker for the capabilities register
module pm_cap_assertions (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic aux_power_sense_i,
  input wire pm_cap_pkg::cfg_req_t cfg_req_i,
  input wire pm_cap_pkg::cfg_rsp_t cfg_rsp_o,
  input wire logic [15:0] power_capabilities_o,
  input wire logic aux_power_status_o,
  input wire logic sample_done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire logic [15:0] pc = power_capabilities_o;
  wire logic dn = sample_done_o;
  a_wake_aux: assert property (dn && aux_power_status_o |-> pc[15:11] == 5'h1f)
    else $error("wake field wrong with aux");
  a_wake_none: assert property (dn && !aux_power_status_o |-> pc[15:11] == 5'h03)
    else $error("wake field wrong without aux");
  a_state_bits: assert property (dn |-> pc[10:9] == 2'h3)
    else $error("state support bits wrong");
  a_fixed_low: assert property (dn |-> pc[8:0] == 9'h021)
    else $error("fixed low fields wrong");
  a_status_hold: assert property (dn |=> dn && $stable(aux_power_status_o))
    else $error("captured status moved");
  a_sense_level: assert property ($rose(dn) |-> aux_power_status_o == !$past(aux_power_sense_i, 4))
    else $error("sense polarity wrong");
  a_read_dword: assert property (cfg_rsp_o.ack && !$past(cfg_req_i.write) &&
    $past(cfg_req_i.index) == 6'h37 && $past(cfg_req_i.byte_en) == 4'hf
    |-> cfg_rsp_o.rdata == {pc, 16'h0001}) else $error("read dword wrong");
  a_write_zero: assert property (cfg_rsp_o.ack && $past(cfg_req_i.write) |-> cfg_rsp_o.rdata == '0)
    else $error("write answer not zero");
  a_retry_early: assert property (cfg_req_i.valid && ce_i && !dn |=> cfg_rsp_o.retry)
    else $error("early request not retried");
  a_parity_even: assert property (cfg_rsp_o.ack && ce_i |=>
    cfg_rsp_o.par == ^{$past(cfg_rsp_o.rdata), $past(cfg_req_i.byte_en, 2)})
    else $error("response parity wrong");
  cover property ($rose(dn) && aux_power_status_o);
  cover property ($rose(dn) && !aux_power_status_o);
  cover property (cfg_rsp_o.retry);
endmodule
bind pm_capabilities_register pm_cap_assertions chk (.mclk_i, .resetn_i, .ce_i,
  .aux_power_sense_i, .cfg_req_i, .cfg_rsp_o, .power_capabilities_o, .aux_power_status_o,
  .sample_done_o);

// ==== test/test_pm_capabilities_register.sv ====
// Self-checking bench for the capabilities register
module test_pm_capabilities_register;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic aux_power_sense_i = 1'b1;
  logic aux = 1'b0;
  pm_cap_pkg::cfg_req_t cfg_req_i;
  pm_cap_pkg::cfg_rsp_t cfg_rsp_o;
  pm_cap_pkg::cfg_rsp_t r;
  logic [15:0] power_capabilities_o;
  logic aux_power_status_o;
  logic sample_done_o;
  int fails = 0;
  int comparisons = 0;
  always #5 mclk_i = ~mclk_i;
  pm_capabilities_register dut (.mclk_i, .resetn_i, .ce_i, .aux_power_sense_i, .cfg_req_i,
    .cfg_rsp_o, .power_capabilities_o, .aux_power_status_o, .sample_done_o);
  pci_host_model host (.mclk_i, .cfg_rsp_i(cfg_rsp_o), .cfg_req_o(cfg_req_i));
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] caps_value(input logic a);
    return {a ? 5'h1f : 5'h03, 2'h3, 3'h0, 1'h1, 1'h0, 1'h0, 3'h1};
  endfunction
  task automatic end_of_test;
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_start;
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    aux_power_sense_i <= !aux;
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    host.cfg(1'b0, 6'h37, 4'hf, '0, r);
    chk({r.ack, r.retry}, 34'h1);
    for (int i = 0; i < 40 && sample_done_o !== 1'b1; i++) @(posedge mclk_i);
    chk({sample_done_o, aux_power_status_o}, {1'b1, aux});
  endtask
  task automatic t_read;
    logic [15:0] e;
    e = caps_value(aux);
    host.cfg(1'b0, 6'h37, 4'hf, '0, r);
    chk({r.ack, r.rdata}, {1'b1, e, 16'h0001});
    chk(power_capabilities_o, e);
    chk(cfg_rsp_o.par, ^{r.rdata, 4'hf});
    host.cfg(1'b0, 6'h37, 4'h6, '0, r);
    chk(r.rdata, {8'h00, e[7:0], 16'h0000});
  endtask
  task automatic t_write;
    host.cfg(1'b1, 6'h37, 4'hf, 32'hffff_ffff, r);
    chk({r.ack, r.rdata}, {1'b1, 32'h0});
    host.cfg(1'b0, 6'h10, 4'hf, '0, r);
    chk({r.ack, r.rdata}, {1'b1, 32'h0});
    host.cfg(1'b0, 6'h37, 4'hf, '0, r);
    chk(r.rdata, {caps_value(aux), 16'h0001});
  endtask
  task automatic t_hold;
    // Pin moves after capture; the held status must not follow it
    aux_power_sense_i <= aux;
    @(posedge mclk_i);
    ce_i <= 1'b0;
    host.cfg(1'b0, 6'h37, 4'hf, '0, r);
    ce_i <= 1'b1;
    chk({r.ack, r.retry}, 34'h0);
    repeat (30) @(posedge mclk_i);
    chk(aux_power_status_o, aux);
    host.cfg(1'b0, 6'h37, 4'hf, '0, r);
    chk(r.rdata, {caps_value(aux), 16'h0001});
  endtask
  initial begin
    for (int k = 0; k < 2; k++) begin
      aux = k[0];
      t_start;
      t_read;
      t_write;
      t_hold;
    end
    end_of_test;
  end
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
endmodule
